// [nsoc_pkg.sv]
// constants shared by the negative-sequence overcurrent element
// assumes a single 20 MHz clock domain and a word-wide register port
package nsoc_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int TICK_PERIOD_NS = 1000000; // timer resolution: 1 ms
    localparam int TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) /
        CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // thresholds in percent of a reference
    // ------------------------------------------------------------
    localparam int PCT_FULL = 100;
    localparam int PCT_RELEASE_MIN = 10;
    localparam int PCT_RELEASE_MAX = 400;  // four times nominal
    localparam int PCT_TOC_PICKUP = 110;
    localparam int PCT_TOC_DROP = 95;
    localparam int PCT_DISK_UNWIND = 90;
    localparam int PCT_DISK_ABORT = 5;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [15:0] IDX_SCOPE = 16'h008C;      // 0140
    localparam logic [15:0] IDX_SWITCH = 16'h0FA1;     // 4001
    localparam logic [15:0] IDX_DT1_PICKUP = 16'h0FA2; // 4002
    localparam logic [15:0] IDX_DT1_DELAY = 16'h0FA3;  // 4003
    localparam logic [15:0] IDX_DT2_PICKUP = 16'h0FA4; // 4004
    localparam logic [15:0] IDX_DT2_DELAY = 16'h0FA5;  // 4005
    localparam logic [15:0] IDX_TOC_PICKUP = 16'h0FA8; // 4008
    localparam logic [15:0] IDX_TOC_DIAL = 16'h0FA9;   // 4009
    localparam logic [15:0] IDX_TOC_RESET = 16'h0FAB;  // 4011
    localparam logic [15:0] IDX_CURVE = 16'h0FB4;      // 4020
    localparam logic [15:0] IDX_NOMINAL = 16'h0FB5;    // 4021
    localparam logic [15:0] IDX_EVT_STATUS = 16'h0FB6; // 4022
    localparam logic [15:0] IDX_EVT_MASK = 16'h0FB7;   // 4023
    localparam logic [15:0] IDX_STATE = 16'h0FB8;      // 4024

    // ------------------------------------------------------------
    // field encodings and reset values
    // ------------------------------------------------------------
    localparam logic [1:0] SCOPE_DISABLED = 2'h0;
    localparam logic [1:0] SCOPE_DEFINITE = 2'h1;
    localparam logic [1:0] SCOPE_CURVE = 2'h2;
    localparam logic CURVE_IEC = 1'h0;
    localparam logic CURVE_ANSI = 1'h1;
    localparam logic RESET_INSTANT = 1'h0;
    localparam logic RESET_DISK = 1'h1;
    localparam int NUM_EVENTS = 6;

    typedef enum logic {TOC_IDLE, TOC_PICKED} toc_state_t;

endpackage

// [negative_sequence_overcurrent.sv]
// negative-sequence overcurrent element: release check, two definite
// stages, one inverse stage, settings registers and an event interrupt
// assumes magnitudes arrive already filtered, in one common unit, and a
// curve evaluator outside supplies per-tick advance and unwind steps
//
// Functional notes
// - feed i2 only when released by currents
// - two definite stages: pickup, timer, trip
// - inverse stage picks up above 110 percent
// - IEC: drop at 95 percent, clear accumulation
// - ANSI: instant or disk emulation reset
// - disk: unwind at or below 90 percent by curve
// - disk: hold between 90 and 95 percent
// - disk: below 5 percent clear at once
// - block input suppresses the whole element
// - loss of release clears running delays
// - scope: definite only, with curve, disabled
// - separate on/off switch enables the element
// - definite stages run beside inverse stage
// - infinite dial: pickup message, never trip
// - each definite stage has own settings
//
// The placing of the registers and strobed register access were chosen for this implementation.
`timescale 1ns/1ps

module negative_sequence_overcurrent
    import nsoc_pkg::*;
#(
    parameter int W = 16,
    parameter int ACC_W = 24,
    parameter int TICK_COUNT = TICK_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic clk_en,
    input wire logic [W-1:0] i2_mag,
    input wire logic [W-1:0] ia_mag,
    input wire logic [W-1:0] ib_mag,
    input wire logic [W-1:0] ic_mag,
    input wire logic [W-1:0] curve_step,
    input wire logic [W-1:0] unwind_step,
    input wire logic block_in,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic dt1_pickup,
    output logic dt1_trip,
    output logic dt2_pickup,
    output logic dt2_trip,
    output logic toc_pickup,
    output logic toc_trip,
    output logic irq
);

    // ------------------------------------------------------------
    // parameter checks
    // ------------------------------------------------------------
    if (W < 8 || W > 24) begin : g_bad_w
        $error("W must lie between 8 and 24");
    end
    if (ACC_W < W || ACC_W > 31) begin : g_bad_acc
        $error("ACC_W must lie between W and 31");
    end
    if (TICK_COUNT < 2) begin : g_bad_tick
        $error("TICK_COUNT must be at least 2");
    end

    // a * 100 >= b * pct, widened so no product overflows
    function automatic logic pct_ge(input logic [W-1:0] a,
            input logic [W-1:0] b, input int pct);
        logic [W+9:0] lhs;
        logic [W+9:0] rhs;
        lhs = (W+10)'(a) * (W+10)'(PCT_FULL);
        rhs = (W+10)'(b) * (W+10)'(pct);
        return lhs >= rhs;
    endfunction

    // a * 100 <= b * pct, same widening; dropout bands are inclusive
    function automatic logic pct_le(input logic [W-1:0] a,
            input logic [W-1:0] b, input int pct);
        return (W+10)'(a) * (W+10)'(PCT_FULL) <= (W+10)'(b) * (W+10)'(pct);
    endfunction

    // word address decode, low byte lanes must be zero
    function automatic logic hit(input logic [15:0] addr,
            input logic [15:0] idx);
        return addr[1:0] == 2'h0 && addr[15:2] == idx[13:0];
    endfunction

    // ------------------------------------------------------------
    // settings registers
    // ------------------------------------------------------------
    logic [1:0] scope_reg;
    logic switch_reg;
    logic [W-1:0] dt_pickup_reg [2];
    logic [W-1:0] dt_delay_reg [2];
    logic [W-1:0] toc_pickup_reg;
    logic [ACC_W-1:0] toc_dial_reg;
    logic reset_mode_reg;
    logic curve_reg;
    logic [W-1:0] nominal_reg;
    logic [NUM_EVENTS-1:0] evt_status_reg;
    logic [NUM_EVENTS-1:0] evt_mask_reg;

    // software writes, one register per strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            scope_reg <= SCOPE_DISABLED;
            switch_reg <= 1'h0;
            dt_pickup_reg[0] <= '1;
            dt_pickup_reg[1] <= '1;
            dt_delay_reg[0] <= '1;
            dt_delay_reg[1] <= '1;
            toc_pickup_reg <= '1;
            toc_dial_reg <= '1;
            reset_mode_reg <= RESET_INSTANT;
            curve_reg <= CURVE_IEC;
            nominal_reg <= '1;
            evt_mask_reg <= '0;
        end else if (clk_en && reg_wr) begin
            if (hit(reg_addr, IDX_SCOPE)) begin
                scope_reg <= reg_wdata[1:0];
            end
            if (hit(reg_addr, IDX_SWITCH)) begin
                switch_reg <= reg_wdata[0];
            end
            if (hit(reg_addr, IDX_DT1_PICKUP)) begin
                dt_pickup_reg[0] <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_DT1_DELAY)) begin
                dt_delay_reg[0] <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_DT2_PICKUP)) begin
                dt_pickup_reg[1] <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_DT2_DELAY)) begin
                dt_delay_reg[1] <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_TOC_PICKUP)) begin
                toc_pickup_reg <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_TOC_DIAL)) begin
                toc_dial_reg <= reg_wdata[ACC_W-1:0];
            end
            if (hit(reg_addr, IDX_TOC_RESET)) begin
                reset_mode_reg <= reg_wdata[0];
            end
            if (hit(reg_addr, IDX_CURVE)) begin
                curve_reg <= reg_wdata[0];
            end
            if (hit(reg_addr, IDX_NOMINAL)) begin
                nominal_reg <= reg_wdata[W-1:0];
            end
            if (hit(reg_addr, IDX_EVT_MASK)) begin
                evt_mask_reg <= reg_wdata[NUM_EVENTS-1:0];
            end
        end
    end

    // ------------------------------------------------------------
    // release and enable
    // ------------------------------------------------------------
    logic released;
    logic element_on;
    logic run;

    // phases at or above four times nominal mean a real fault, not imbalance
    assign released = pct_ge(i2_mag, nominal_reg, PCT_RELEASE_MIN) &&
        !pct_ge(ia_mag, nominal_reg, PCT_RELEASE_MAX) &&
        !pct_ge(ib_mag, nominal_reg, PCT_RELEASE_MAX) &&
        !pct_ge(ic_mag, nominal_reg, PCT_RELEASE_MAX);
    assign element_on = switch_reg && (scope_reg == SCOPE_DEFINITE ||
        scope_reg == SCOPE_CURVE);
    // losing any term drops every stage and its timer in one cycle
    assign run = element_on && !block_in && released;

    // ------------------------------------------------------------
    // millisecond tick
    // ------------------------------------------------------------
    logic [$clog2(TICK_COUNT)-1:0] tick_cnt_reg;
    logic tick;

    assign tick = tick_cnt_reg == ($clog2(TICK_COUNT))'(TICK_COUNT - 1);

    // free-running prescaler, so a delay may start mid-tick (up to 1 ms)
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_reg <= '0;
        end else if (clk_en) begin
            tick_cnt_reg <= tick ? '0 : tick_cnt_reg + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // definite-time stages
    // ------------------------------------------------------------
    logic [1:0] dt_pick_reg;
    logic [1:0] dt_trip_reg;

    // both stages share the qualified current, independent settings
    for (genvar s = 0; s < 2; s++) begin : g_dt
        logic [W-1:0] timer_reg;
        logic above;

        assign above = run && i2_mag >= dt_pickup_reg[s];

        // timer counts ticks while picked; cleared on dropout
        always_ff @(posedge clock or negedge rstn) begin
            if (!rstn) begin
                timer_reg <= '0;
                dt_pick_reg[s] <= 1'h0;
                dt_trip_reg[s] <= 1'h0;
            end else if (clk_en) begin
                dt_pick_reg[s] <= above;
                if (!above) begin
                    timer_reg <= '0;
                    dt_trip_reg[s] <= 1'h0;
                end else if (timer_reg >= dt_delay_reg[s]) begin
                    dt_trip_reg[s] <= 1'h1;
                end else if (tick) begin
                    timer_reg <= timer_reg + 1'b1;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // inverse-time stage
    // ------------------------------------------------------------
    toc_state_t toc_state_reg;
    logic [ACC_W-1:0] acc_reg;
    logic toc_trip_reg;
    logic toc_run;
    logic over_pu;
    logic below_drop;
    logic below_unwind;
    logic below_abort;
    logic disk;
    logic dial_inf;

    assign toc_run = run && scope_reg == SCOPE_CURVE;
    assign over_pu = !pct_le(i2_mag, toc_pickup_reg, PCT_TOC_PICKUP);
    assign below_drop = pct_le(i2_mag, toc_pickup_reg, PCT_TOC_DROP);
    assign below_unwind = pct_le(i2_mag, toc_pickup_reg, PCT_DISK_UNWIND);
    assign below_abort = !pct_ge(i2_mag, toc_pickup_reg, PCT_DISK_ABORT);
    assign disk = curve_reg == CURVE_ANSI && reset_mode_reg == RESET_DISK;
    assign dial_inf = &toc_dial_reg; // all ones stands for infinity

    // pickup state: up above 110 percent, down at or below 95 percent
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            toc_state_reg <= TOC_IDLE;
        end else if (clk_en) begin
            case (toc_state_reg)
                TOC_IDLE: begin
                    if (toc_run && over_pu) begin
                        toc_state_reg <= TOC_PICKED;
                    end
                end
                TOC_PICKED: begin
                    if (!toc_run || below_drop) begin
                        toc_state_reg <= TOC_IDLE;
                    end
                end
                default: toc_state_reg <= TOC_IDLE;
            endcase
        end
    end

    // accumulated travel toward trip, or disc position under emulation
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            acc_reg <= '0;
        end else if (clk_en) begin
            if (!toc_run) begin
                acc_reg <= '0;
            end else if (toc_state_reg == TOC_PICKED && !below_drop) begin
                if (tick) begin
                    acc_reg <= (ACC_W'(acc_reg) + ACC_W'(curve_step) <
                        acc_reg) ? '1 : acc_reg + ACC_W'(curve_step);
                end
            end else if (!disk) begin
                acc_reg <= '0;
            end else if (below_abort) begin
                acc_reg <= '0;
            end else if (below_unwind) begin
                if (tick) begin
                    acc_reg <= (acc_reg > ACC_W'(unwind_step)) ?
                        acc_reg - ACC_W'(unwind_step) : '0;
                end
            end
            // otherwise between 90 and the pickup: disc stands still
        end
    end

    // trip once accumulation reaches the dial, never at infinity
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            toc_trip_reg <= 1'h0;
        end else if (clk_en) begin
            if (toc_state_reg != TOC_PICKED || !toc_run || below_drop) begin
                toc_trip_reg <= 1'h0;
            end else if (!dial_inf && acc_reg >= toc_dial_reg) begin
                toc_trip_reg <= 1'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dt1_pickup <= 1'h0;
            dt1_trip <= 1'h0;
            dt2_pickup <= 1'h0;
            dt2_trip <= 1'h0;
            toc_pickup <= 1'h0;
            toc_trip <= 1'h0;
        end else if (clk_en) begin
            dt1_pickup <= dt_pick_reg[0];
            dt1_trip <= dt_trip_reg[0];
            dt2_pickup <= dt_pick_reg[1];
            dt2_trip <= dt_trip_reg[1];
            toc_pickup <= toc_state_reg == TOC_PICKED;
            toc_trip <= toc_trip_reg;
        end
    end

    // ------------------------------------------------------------
    // events and interrupt
    // ------------------------------------------------------------
    logic [NUM_EVENTS-1:0] evt_level;
    logic [NUM_EVENTS-1:0] evt_prev_reg;
    logic [NUM_EVENTS-1:0] evt_rise;
    logic [NUM_EVENTS-1:0] evt_clear;

    assign evt_level = {toc_trip, toc_pickup, dt2_trip, dt2_pickup,
        dt1_trip, dt1_pickup};
    assign evt_rise = evt_level & ~evt_prev_reg;
    assign evt_clear = (reg_wr && hit(reg_addr, IDX_EVT_STATUS)) ?
        reg_wdata[NUM_EVENTS-1:0] : '0;

    // a rising edge in the clearing cycle still sets the bit
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            evt_prev_reg <= '0;
            evt_status_reg <= '0;
            irq <= 1'h0;
        end else if (clk_en) begin
            evt_prev_reg <= evt_level;
            evt_status_reg <= (evt_status_reg & ~evt_clear) | evt_rise;
            irq <= |(evt_status_reg & evt_mask_reg);
        end
    end

    // ------------------------------------------------------------
    // register read port
    // ------------------------------------------------------------
    logic [31:0] rd_mux;

    // unmapped addresses read as zero
    always_comb begin
        rd_mux = '0;
        if (hit(reg_addr, IDX_SCOPE)) rd_mux = 32'(scope_reg);
        if (hit(reg_addr, IDX_SWITCH)) rd_mux = 32'(switch_reg);
        if (hit(reg_addr, IDX_DT1_PICKUP)) rd_mux = 32'(dt_pickup_reg[0]);
        if (hit(reg_addr, IDX_DT1_DELAY)) rd_mux = 32'(dt_delay_reg[0]);
        if (hit(reg_addr, IDX_DT2_PICKUP)) rd_mux = 32'(dt_pickup_reg[1]);
        if (hit(reg_addr, IDX_DT2_DELAY)) rd_mux = 32'(dt_delay_reg[1]);
        if (hit(reg_addr, IDX_TOC_PICKUP)) rd_mux = 32'(toc_pickup_reg);
        if (hit(reg_addr, IDX_TOC_DIAL)) rd_mux = 32'(toc_dial_reg);
        if (hit(reg_addr, IDX_TOC_RESET)) rd_mux = 32'(reset_mode_reg);
        if (hit(reg_addr, IDX_CURVE)) rd_mux = 32'(curve_reg);
        if (hit(reg_addr, IDX_NOMINAL)) rd_mux = 32'(nominal_reg);
        if (hit(reg_addr, IDX_EVT_STATUS)) rd_mux = 32'(evt_status_reg);
        if (hit(reg_addr, IDX_EVT_MASK)) rd_mux = 32'(evt_mask_reg);
        if (hit(reg_addr, IDX_STATE)) begin
            rd_mux = 32'({acc_reg, released, run, evt_level});
        end
    end

    // read data stands for exactly the cycle after the strobe
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            reg_rdata <= '0;
        end else if (clk_en) begin
            reg_rdata <= reg_rd ? rd_mux : '0;
        end
    end

endmodule

// [negative_sequence_overcurrent_monitor.sv]
// checker for the negative-sequence overcurrent element
// assumes it is bound to the top module and sees only its ports
`timescale 1ns/1ps

module nsoc_monitor (
    input logic clock,
    input logic rstn,
    input logic clk_en,
    input logic block_in,
    input logic [15:0] reg_addr,
    input logic reg_wr,
    input logic reg_rd,
    input logic [31:0] reg_rdata,
    input logic dt1_pickup,
    input logic dt1_trip,
    input logic dt2_pickup,
    input logic dt2_trip,
    input logic toc_pickup,
    input logic toc_trip,
    input logic irq
);
    // ------------------------------------------------------------
    // one clock domain, so clock and reset are given once
    // ------------------------------------------------------------
    default clocking mon_cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    // trips only while the owning stage is picked up
    dt1_trip_held_a: assert property (dt1_trip |-> dt1_pickup)
        else $error("dt1 trip without pickup");
    dt2_trip_held_a: assert property (dt2_trip |-> dt2_pickup)
        else $error("dt2 trip without pickup");
    toc_trip_held_a: assert property (toc_trip |-> toc_pickup)
        else $error("inverse trip without pickup");
    // a trip comes after its pickup, never with it, unless its definite delay is zero
    dt1_trip_order_a: assert property ($rose(dt1_trip) |->
        $past(dt1_pickup))
        else $error("dt1 trip before pickup");
    toc_trip_order_a: assert property ($rose(toc_trip) |->
        $past(toc_pickup))
        else $error("inverse trip before pickup");
    // the block input empties every stage within a few cycles
    block_clears_a: assert property ((block_in && clk_en)[*4] |->
        !dt1_pickup && !dt2_pickup && !toc_pickup)
        else $error("pickup while blocked");
    pickup_unblocked_a: assert property ($rose(dt1_pickup) |->
        !$past(block_in, 2))
        else $error("pickup rose from a blocked cycle");
    // read data stands only in the cycle after a read
    rdata_idle_a: assert property (!reg_rd && clk_en |=> reg_rdata == 32'h0)
        else $error("read data outside read answer");
    misaligned_read_a: assert property (reg_rd && clk_en &&
        reg_addr[1:0] != 2'h0 |=> reg_rdata == 32'h0)
        else $error("misaligned read returned data");
    // the interrupt falls only through a status or mask write
    irq_clear_a: assert property ($fell(irq) |-> $past(reg_wr, 2))
        else $error("irq fell without a register write");

    dt1_trip_c: cover property ($rose(dt1_trip));
    toc_trip_c: cover property ($rose(toc_trip));
    toc_pickup_c: cover property ($rose(toc_pickup));
    irq_c: cover property ($rose(irq));
endmodule

bind negative_sequence_overcurrent nsoc_monitor nsoc_monitor_i (
    .clock(clock),
    .rstn(rstn),
    .clk_en(clk_en),
    .block_in(block_in),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .dt1_pickup(dt1_pickup),
    .dt1_trip(dt1_trip),
    .dt2_pickup(dt2_pickup),
    .dt2_trip(dt2_trip),
    .toc_pickup(toc_pickup),
    .toc_trip(toc_trip),
    .irq(irq)
);

// [negative_sequence_overcurrent_test.sv]
// self-checking bench for the negative-sequence overcurrent element
// assumes the package and design are compiled first; tick shortened to 4
`timescale 1ns/1ps

`define CHK(got, exp) begin checked++; if ((got) !== (exp)) begin \
    n_errors++; $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); \
    end end

module negative_sequence_overcurrent_test import nsoc_pkg::*;;
    localparam int DT1P = 0, DT1T = 1, DT2P = 2, DT2T = 3;
    localparam int TOCP = 4, TOCT = 5, IRQB = 6;
    logic clock = 1'h0, rstn = 1'h0, clk_en = 1'h1, block_in = 1'h0;
    logic reg_wr = 1'h0, reg_rd = 1'h0;
    logic [15:0] i2_mag = 16'h0, ia_mag = 16'h000A, ib_mag = 16'h000A;
    logic [15:0] ic_mag = 16'h000A, curve_step = 16'h0001;
    logic [15:0] unwind_step = 16'h0002, reg_addr = 16'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic [31:0] reg_rdata;
    logic dt1_pickup, dt1_trip, dt2_pickup, dt2_trip, toc_pickup, toc_trip;
    logic irq;
    int n_errors = 0, checked = 0;
    wire logic [6:0] outs = {irq, toc_trip, toc_pickup, dt2_trip, dt2_pickup,
        dt1_trip, dt1_pickup};

    always #25 clock = ~clock;

    negative_sequence_overcurrent #(
        .TICK_COUNT(4)
    ) negative_sequence_overcurrent_i (
        .clock(clock), .rstn(rstn), .clk_en(clk_en), .i2_mag(i2_mag),
        .ia_mag(ia_mag), .ib_mag(ib_mag), .ic_mag(ic_mag),
        .curve_step(curve_step), .unwind_step(unwind_step),
        .block_in(block_in), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .dt1_pickup(dt1_pickup), .dt1_trip(dt1_trip),
        .dt2_pickup(dt2_pickup), .dt2_trip(dt2_trip),
        .toc_pickup(toc_pickup), .toc_trip(toc_trip), .irq(irq));

    // ------------------------------------------------------------
    // bus and stimulus tasks
    // ------------------------------------------------------------
    function logic [15:0] ba(input logic [15:0] idx);
        return {idx[13:0], 2'h0};
    endfunction
    task wr(input logic [15:0] idx, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= ba(idx);
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge clock);
        reg_wr <= 1'h0;
    endtask
    // read data is looked at only in the cycle after the strobe
    task rd(input logic [15:0] addr, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= addr;
        reg_rd <= 1'h1;
        @(posedge clock);
        reg_rd <= 1'h0;
        #1;
        `CHK(reg_rdata, exp)
    endtask
    task drive(input logic [15:0] i2, input logic [15:0] ph);
        @(posedge clock);
        i2_mag <= i2;
        ia_mag <= ph;
    endtask
    // bounded wait for an output level; exp says whether it must come
    task wait_out(input int b, input logic v, input int n, input logic exp);
        logic hit;
        hit = 1'h0;
        repeat (n) begin
            @(posedge clock);
            #1;
            if (outs[b] === v) begin
                hit = 1'h1;
                break;
            end
        end
        `CHK(hit, exp)
    endtask
    // slow means the accumulator restarted from zero, so trip takes 10 ticks
    task retrip(input logic fast);
        drive(16'h002D, 16'h000A);
        wait_out(TOCT, 1'h1, 32, fast);
        if (!fast) wait_out(TOCT, 1'h1, 24, 1'h1);
    endtask
    task test_done;
        if (n_errors == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // hang guard: a run that never reaches the end counts as a failure
    initial begin
        repeat (100000) @(posedge clock);
        n_errors++;
        test_done();
    end

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (8) @(posedge clock);
        rstn <= 1'h1;
        rd(ba(IDX_SCOPE), 32'h0);
        rd(ba(IDX_SWITCH), 32'h0);
        rd(ba(IDX_DT2_PICKUP), 32'h0000FFFF);
        wr(IDX_NOMINAL, 32'hFA);
        wr(IDX_DT1_PICKUP, 32'h14);
        wr(IDX_DT1_DELAY, 32'h2);
        wr(IDX_DT2_PICKUP, 32'h32);
        wr(IDX_DT2_DELAY, 32'h0);
        wr(IDX_TOC_PICKUP, 32'h28);
        wr(IDX_TOC_DIAL, 32'hA);
        wr(IDX_SCOPE, {30'h0, SCOPE_DEFINITE});
        wr(IDX_SWITCH, 32'h1);
        rd(ba(IDX_DT2_PICKUP), 32'h32);
        // release floor at 10 percent of nominal 250: 24 fails, 25 holds
        drive(16'h0018, 16'h000A);
        wait_out(DT1P, 1'h1, 12, 1'h0);
        drive(16'h0019, 16'h000A);
        wait_out(DT1P, 1'h1, 6, 1'h1);
        wr(IDX_NOMINAL, 32'hA);
        // phase ceiling at four times nominal 10: 40 loses release
        drive(16'h001E, 16'h0028);
        wait_out(DT1P, 1'h0, 6, 1'h1);
        `CHK(dt1_trip, 1'h0)
        drive(16'h001E, 16'h0027);
        wait_out(DT1P, 1'h1, 6, 1'h1);
        `CHK(dt2_pickup, 1'h0)
        wait_out(DT1T, 1'h1, 16, 1'h1);
        drive(16'h003C, 16'h000A);
        wait_out(DT2T, 1'h1, 12, 1'h1);
        `CHK(toc_pickup, 1'h0)
        @(posedge clock);
        block_in <= 1'h1;
        wait_out(DT2P, 1'h0, 6, 1'h1);
        `CHK(dt1_pickup, 1'h0)
        @(posedge clock);
        block_in <= 1'h0;
        wait_out(DT2P, 1'h1, 6, 1'h1);
        drive(16'h001E, 16'h000A);
        wait_out(DT2P, 1'h0, 6, 1'h1);
        `CHK(dt2_trip, 1'h0)
        `CHK(dt1_pickup, 1'h1)
        wr(IDX_SWITCH, 32'h0);
        wait_out(DT1P, 1'h0, 6, 1'h1);
        wr(IDX_SWITCH, 32'h1);
        wr(IDX_SCOPE, 32'h0);
        wait_out(DT1P, 1'h0, 6, 1'h1);
        wr(IDX_SCOPE, {30'h0, SCOPE_CURVE});
        // 44 is exactly 110 percent of 40, so it must not pick up
        drive(16'h002C, 16'h000A);
        wait_out(TOCP, 1'h1, 12, 1'h0);
        // immediate dropout: IEC, then ANSI with instant reset
        for (int k = 0; k < 2; k++) begin
            wr(IDX_CURVE, k);
            wr(IDX_TOC_RESET, {31'h0, RESET_INSTANT});
            drive(16'h0000, 16'h000A);
            drive(16'h002D, 16'h000A);
            wait_out(TOCP, 1'h1, 6, 1'h1);
            `CHK(dt1_pickup, 1'h1)
            wait_out(TOCT, 1'h1, 24, 1'h0);
            drive(16'h0026, 16'h000A);
            wait_out(TOCP, 1'h0, 6, 1'h1);
            retrip(1'h0);
        end
        // disk emulation: hold, unwind and abort
        wr(IDX_TOC_RESET, {31'h0, RESET_DISK});
        drive(16'h0000, 16'h000A);
        drive(16'h002D, 16'h000A);
        wait_out(TOCT, 1'h1, 24, 1'h0);
        drive(16'h0025, 16'h000A);
        repeat (32) @(posedge clock);
        retrip(1'h1);
        drive(16'h0024, 16'h000A);
        repeat (40) @(posedge clock);
        retrip(1'h0);
        drive(16'h0001, 16'h000A);
        repeat (8) @(posedge clock);
        retrip(1'h0);
        // infinite dial: pickup but no trip
        wr(IDX_TOC_DIAL, 32'h00FFFFFF);
        drive(16'h0000, 16'h000A);
        // big steps saturate the accumulator, so only the dial keeps it off
        curve_step <= 16'hFFFF;
        drive(16'h002D, 16'h000A);
        wait_out(TOCP, 1'h1, 6, 1'h1);
        wait_out(TOCT, 1'h1, 1200, 1'h0);
        // event status, mask and interrupt
        drive(16'h0000, 16'h000A);
        wr(IDX_DT1_DELAY, 32'h64);
        wr(IDX_EVT_STATUS, 32'h3F);
        rd(ba(IDX_EVT_STATUS), 32'h0);
        drive(16'h001E, 16'h000A);
        wait_out(DT1P, 1'h1, 6, 1'h1);
        rd(ba(IDX_EVT_STATUS), 32'h1);
        `CHK(irq, 1'h0)
        wr(IDX_EVT_MASK, 32'h1);
        wait_out(IRQB, 1'h1, 4, 1'h1);
        wr(IDX_EVT_STATUS, 32'h1);
        wait_out(IRQB, 1'h0, 4, 1'h1);
        rd(ba(IDX_EVT_STATUS), 32'h0);
        rd(16'hFFF0, 32'h0);
        rd(ba(IDX_SWITCH) | 16'h0002, 32'h0);
        test_done();
    end
endmodule
